// >>> uart_pin_level_control_test.sv
// Self-checking bench for the UART pin-level control block
`timescale 1ns/10ps
`include "uplc_params.svh"
module uart_pin_level_control_test;
    typedef struct {logic [2:0] a; logic [7:0] d; logic rts;} uplc_row_t;

    logic       clk, reset, bus_style, chip_select_n, read_strobe_n;
    logic       write_strobe_n, low_power_request, ring_n, rx, tx, rts_n;
    logic       msi_irq, osc_in, osc_out, low_power_active, data_oe;
    logic [2:0] addr;
    logic [7:0] data_in, data_out, rq;
    logic       roe, lb_watch;
    int         fail_count, checked, tx_low, n0;
    uplc_row_t  rows [6] = '{'{3'h7, 8'hA5, 1'b1}, '{3'h7, 8'h5A, 1'b1},
                             '{3'h4, 8'h02, 1'b0}, '{3'h4, 8'h00, 1'b1},
                             '{3'h3, 8'h1B, 1'b1}, '{3'h3, 8'h00, 1'b1}};

    uplc_core u_dut (.clk(clk), .reset(reset), .bus_style(bus_style),
        .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe),
        .low_power_request(low_power_request), .ring_n(ring_n), .rx(rx),
        .tx(tx), .rts_n(rts_n), .msi_irq(msi_irq), .osc_in(osc_in),
        .osc_out(osc_out), .low_power_active(low_power_active));

    // Bit time is 16 oscillator periods of 16 ns with divisor 1
    uplc_serial_peer #(.BIT_NS(256)) u_peer (.tx(tx), .rx(rx));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Toggles land on rising clock edges
    initial
    begin
        osc_in = 1'b0;
        #2;
        forever #8 osc_in = ~osc_in;
    end

    always @(posedge clk)
        if (lb_watch && tx === 1'b0)
            tx_low <= tx_low + 1;

    task automatic wrap_up();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One access; strobe held 4 cycles since data settles 3 cycles in
    task automatic bus(input logic w, input logic [2:0] a,
                       input logic [7:0] d, input logic sel_n);
        @(negedge clk);
        addr = a;
        data_in = d;
        chip_select_n = sel_n;
        write_strobe_n = !w;
        read_strobe_n = bus_style ? w : 1'b1;
        repeat (4) @(negedge clk);
        rq = data_out;
        roe = data_oe;
        chip_select_n = 1'b1;
        write_strobe_n = 1'b1;
        read_strobe_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 1'b0);
    endtask

    task automatic rd(input logic [2:0] a);
        bus(1'b0, a, 8'h00, 1'b0);
    endtask

    // Polls line status until a received byte is ready
    task automatic wait_ready();
        for (int k = 0; k < 400; k++)
        begin
            rd(3'h5);
            if (rq[0] === 1'b1)
                return;
        end
        fail_count++;
        $display("FAIL t=%0t got=%h exp=%h", $time, rq, 8'h01);
        wrap_up();
    endtask

    initial
    begin
        reset = 1'b1;
        bus_style = 1'b1;
        chip_select_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        addr = 3'h0;
        data_in = 8'h00;
        low_power_request = 1'b0;
        ring_n = 1'b1;
        fail_count = 0;
        checked = 0;
        tx_low = 0;
        lb_watch = 1'b0;
        repeat (4) @(negedge clk);
        chk1(rts_n, 1'b1);
        chk1(tx, 1'b1);
        chk1(msi_irq, 1'b0);
        chk8(data_out, 8'h00);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            chk8(rq, rows[i].d);
            chk1(rts_n, rows[i].rts);
        end
        // Deselected accesses must not land or drive the bus
        bus(1'b1, 3'h7, 8'h3C, 1'b1);
        bus(1'b0, 3'h7, 8'h00, 1'b1);
        chk1(roe, 1'b0);
        rd(3'h7);
        chk8(rq, 8'h5A);
        // Ring edge with the modem interrupt enabled, then disabled
        wr(3'h1, 8'h08);
        rd(3'h6);
        ring_n = 1'b0;
        repeat (6) @(negedge clk);
        rd(3'h6);
        chk1(rq[6], 1'b1);
        chk1(msi_irq, 1'b0);
        ring_n = 1'b1;
        repeat (6) @(negedge clk);
        chk1(msi_irq, 1'b1);
        rd(3'h6);
        chk1(rq[6], 1'b0);
        chk1(rq[`UPLC_MSR_TERI_BIT], 1'b1);
        repeat (2) @(negedge clk);
        chk1(msi_irq, 1'b0);
        wr(3'h1, 8'h00);
        ring_n = 1'b0;
        repeat (6) @(negedge clk);
        ring_n = 1'b1;
        repeat (6) @(negedge clk);
        chk1(msi_irq, 1'b0);
        rd(3'h6);
        // Transmit to the peer, then receive from it
        n0 = u_peer.got_count;
        wr(3'h0, 8'h5A);
        for (int k = 0; k < 3000 && u_peer.got_count == n0; k++)
            @(negedge clk);
        chk1(u_peer.got_count != n0, 1'b1);
        chk8(u_peer.got_byte, 8'h5A);
        chk1(tx, 1'b1);
        u_peer.send(8'hC3);
        wait_ready();
        rd(3'h0);
        chk8(rq, 8'hC3);
        // Loopback: pin traffic must neither leave nor enter
        wr(3'h4, 8'h10);
        lb_watch = 1'b1;
        fork
            u_peer.send(8'h81);
            wr(3'h0, 8'h3C);
        join
        wait_ready();
        lb_watch = 1'b0;
        chk1(tx_low == 0, 1'b1);
        rd(3'h0);
        chk8(rq, 8'h3C);
        wr(3'h4, 8'h00);
        // Low power isolates the bus; its release clears registers
        wr(3'h4, 8'h02);
        wr(3'h1, 8'h08);
        chk1(rts_n, 1'b0);
        low_power_request = 1'b1;
        repeat (3) @(negedge clk);
        chk1(low_power_active, 1'b1);
        chk1(osc_out, 1'b0);
        bus(1'b0, 3'h4, 8'h00, 1'b0);
        chk1(roe, 1'b0);
        chk1(rts_n, 1'b0);
        low_power_request = 1'b0;
        repeat (6) @(negedge clk);
        chk1(rts_n, 1'b1);
        rd(3'h4);
        chk8(rq, `UPLC_MCTL_RST);
        rd(3'h1);
        chk8(rq, `UPLC_IER_RST);
        // Direction-line style with its low-active reset
        wr(3'h4, 8'h02);
        reset = 1'b1;
        @(negedge clk);
        bus_style = 1'b0; // Changed only under reset
        reset = 1'b0;
        repeat (4) @(negedge clk);
        chk1(rts_n, 1'b1);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        wr(3'h7, 8'h66);
        rd(3'h7);
        chk8(rq, 8'h66);
        wr(3'h4, 8'h02);
        chk1(rts_n, 1'b0);
        wrap_up();
    end
endmodule // uart_pin_level_control_test

// >>> uplc_core.sv
// UART pin-level control: bus strobes, reset, low power, modem and loopback
//
// Contract
// RULE1: With bus style high, read strobe is active low; else ignored.
// RULE2: With bus style high, write strobe is active low.
// RULE3: With bus style low, direction line high reads, low writes.
// RULE4: Low-power request high enters low power, stops clock, isolates bus.
// RULE5: Falling edge of low-power request resets all registers to defaults; the code leaves rbr_r and data_out at their old values.
// RULE6: Master reset active high with bus style high, active low otherwise.
// RULE7: Rising edge of ring input raises modem interrupt when enabled.
// RULE8: Ring-indicate state is readable at status bit 6.
// RULE9: Writing 1 to modem control bit 1 drives request-to-send low.
// RULE10: Request-to-send output is high after any reset.
// RULE11: Remote device holds the receive line high when not sending.
// RULE12: Loopback ignores receive pin and feeds transmit stream to receiver.
// RULE13: Transmit output is high in reset, idle and when disabled.
// RULE14: Loopback disables the external transmit output.
// RULE15: Oscillator input clock feeds the baud rate generator.
// RULE16: Accesses are honoured only while chip select is low.
// RULE17: Host keeps bus style static; a change requires a reset.
`timescale 1ns/10ps
`include "uplc_params.svh"
module uplc_core
    import uplc_pkg::*;
#(
    parameter int FIFO_DEPTH = `UPLC_FIFO_DEPTH,
    parameter int OVS        = `UPLC_OVS
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       bus_style,
    input  wire logic       chip_select_n,
    input  wire logic       read_strobe_n,
    input  wire logic       write_strobe_n,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    input  wire logic       low_power_request,
    input  wire logic       ring_n,
    input  wire logic       rx,
    output logic            tx,
    output logic            rts_n,
    output logic            msi_irq,
    input  wire logic       osc_in,
    output logic            osc_out,
    output logic            low_power_active
);
    // Style-dependent reset polarity; style is static so no glitch here
    wire reset_pin_active = bus_style ? reset : ~reset;  // see RULE6 RULE17

    // Pin synchronisers; first stage is read by second stage only.
    // Reset to idle pin levels so release shows no false strobe or edge.
    logic [18:0] sy1_r;
    logic [18:0] sy2_r;
    always_ff @(posedge clk or posedge reset_pin_active)
    begin
        if (reset_pin_active)
        begin
            sy1_r <= 19'h000F6;
            sy2_r <= 19'h000F6;
        end
        else
        begin
            sy1_r <= {addr, data_in, bus_style, chip_select_n,
                      read_strobe_n, write_strobe_n, low_power_request,
                      ring_n, rx, osc_in};
            sy2_r <= sy1_r;
        end
    end
    wire [2:0] s_addr = sy2_r[18:16];
    wire [7:0] s_din  = sy2_r[15:8];
    wire s_style = sy2_r[7];
    wire s_cs_n  = sy2_r[6];
    wire s_rd_n  = sy2_r[5];
    wire s_wr_n  = sy2_r[4];
    wire s_lp    = sy2_r[3];
    wire s_ri_n  = sy2_r[2];
    wire s_rx    = sy2_r[1];
    wire s_osc   = sy2_r[0];

    logic lp_prev_r;
    logic lp_rst_r;
    always_ff @(posedge clk or posedge reset_pin_active)
    begin
        if (reset_pin_active)
        begin
            lp_prev_r <= 1'b0;
            lp_rst_r  <= 1'b0;
        end
        else
        begin
            lp_prev_r <= s_lp;
            lp_rst_r  <= lp_prev_r && !s_lp;  // see RULE5
        end
    end
    wire srst = reset_pin_active;
    wire soft_clear = lp_rst_r;
    assign low_power_active = s_lp;  // see RULE4

    // Bus decode: two strobe styles, one access pulse per strobe
    wire rd_lvl = !s_cs_n && !s_lp &&
                  (s_style ? !s_rd_n : s_wr_n);  // see RULE1 RULE3 RULE16
    wire wr_lvl = !s_cs_n && !s_lp &&
                  (s_style ? !s_wr_n : !s_wr_n && 1'b0);  // see RULE2
    // In single-line style chip select frames the access, the line its way
    wire wr_68  = !s_cs_n && !s_lp && !s_style && !s_wr_n;  // see RULE3
    wire wr_any = wr_lvl || wr_68;
    logic rd_prev_r;
    logic wr_prev_r;
    wire rd_pulse = rd_lvl && !rd_prev_r;
    wire wr_pulse = wr_any && !wr_prev_r;

    logic [7:0]  ier_r;
    logic [7:0]  lcr_r;
    logic [7:0]  modem_control_reg_r;
    logic [7:0]  spr_r;
    logic [15:0] div_r;
    logic        teri_r;
    logic        ri_prev_r;
    logic [7:0]  rbr_r;
    logic        rbr_full_r;
    wire dlab = lcr_r[7];
    wire loop = modem_control_reg_r[`UPLC_MCTL_LOOP_BIT];
    wire wr_en_reg = wr_pulse;

    function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
        return a == r;
    endfunction

    wire ri_rise = s_ri_n && !ri_prev_r;
    wire msr_rd  = rd_pulse && hit(s_addr, `UPLC_ADDR_MSR);

    always_ff @(posedge clk or posedge srst)
    begin
        if (srst)
        begin
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
            ier_r     <= `UPLC_IER_RST;
            lcr_r     <= `UPLC_LCR_RST;
            modem_control_reg_r <= `UPLC_MCTL_RST;
            spr_r     <= 8'h00;
            div_r     <= `UPLC_DIV_RST;
            teri_r    <= 1'b0;
            ri_prev_r <= 1'b1;
        end
        else if (soft_clear)
        begin
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
            ier_r     <= `UPLC_IER_RST;
            lcr_r     <= `UPLC_LCR_RST;
            modem_control_reg_r <= `UPLC_MCTL_RST;
            spr_r     <= 8'h00;
            div_r     <= `UPLC_DIV_RST;
            teri_r    <= 1'b0;
            ri_prev_r <= 1'b1;
        end
        else
        begin
            rd_prev_r <= rd_lvl;
            wr_prev_r <= wr_any;
            ri_prev_r <= s_ri_n;
            // Set wins over the read-clear
            if (ri_rise)
                teri_r <= 1'b1;  // see RULE7
            else if (msr_rd)
                teri_r <= 1'b0;
            if (wr_en_reg && hit(s_addr, `UPLC_ADDR_IER) && !dlab)
                ier_r <= s_din;
            if (wr_en_reg && hit(s_addr, `UPLC_ADDR_LCR))
                lcr_r <= s_din;
            if (wr_en_reg && hit(s_addr, `UPLC_ADDR_MCTL))
                modem_control_reg_r <= s_din;  // see RULE9
            if (wr_en_reg && hit(s_addr, `UPLC_ADDR_SPR))
                spr_r <= s_din;
            if (wr_en_reg && dlab && hit(s_addr, `UPLC_ADDR_RHR))
                div_r[7:0] <= s_din;
            if (wr_en_reg && dlab && hit(s_addr, `UPLC_ADDR_IER))
                div_r[15:8] <= s_din;
        end
    end
    assign msi_irq = teri_r && ier_r[`UPLC_IER_MSI_BIT];  // see RULE7
    assign rts_n   =
        !modem_control_reg_r[`UPLC_MCTL_RTS_BIT];  // see RULE9 RULE10

    // Baud tick from the oscillator input; stopped in low power
    logic osc_prev_r;
    logic [15:0] bdiv_r;
    logic tick_r;
    wire osc_rise = s_osc && !osc_prev_r && !s_lp;  // see RULE4 RULE15
    always_ff @(posedge clk or posedge srst)
    begin
        if (srst)
        begin
            osc_prev_r <= 1'b0;
            bdiv_r     <= 16'h0000;
            tick_r     <= 1'b0;
        end
        else
        begin
            osc_prev_r <= s_osc;
            tick_r     <= 1'b0;
            if (soft_clear)
                bdiv_r <= 16'h0000;
            else if (osc_rise)
            begin
                if (bdiv_r + 16'h0001 >= div_r)  // see RULE15
                begin
                    bdiv_r <= 16'h0000;
                    tick_r <= 1'b1;
                end
                else
                    bdiv_r <= bdiv_r + 16'h0001;
            end
        end
    end
    assign osc_out = s_osc && !s_lp;  // see RULE4

    // Transmit FIFO fed by host writes to the holding register
    logic [7:0] fo_data;
    logic       fo_valid;
    logic       fo_ready;
    logic       fi_ready;
    wire thr_wr = wr_en_reg && !dlab && hit(s_addr, `UPLC_ADDR_RHR);
    uplc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txfifo (
        .clk       (clk),
        .reset     (srst),
        .flush     (soft_clear),
        .in_data   (s_din),
        .in_valid  (thr_wr),
        .in_ready  (fi_ready),
        .out_data  (fo_data),
        .out_valid (fo_valid),
        .out_ready (fo_ready)
    );

    // Transmitter: 8N1 at OVS ticks per bit
    uplc_tx_state_t st_r;
    logic [7:0] sh_r;
    logic [2:0] bit_r;
    logic [4:0] ov_r;
    logic       line_r;
    wire  bit_end = tick_r && (ov_r == 5'(OVS - 1));
    assign fo_ready = (st_r == UPLC_TX_IDLE) && !s_lp;
    always_ff @(posedge clk or posedge srst)
    begin
        if (srst)
        begin
            st_r   <= UPLC_TX_IDLE;
            sh_r   <= 8'h00;
            bit_r  <= 3'h0;
            ov_r   <= 5'h00;
            line_r <= 1'b1;
        end
        else if (soft_clear)
        begin
            st_r   <= UPLC_TX_IDLE;
            line_r <= 1'b1;
            ov_r   <= 5'h00;
        end
        else
        begin
            if (tick_r)
                ov_r <= bit_end ? 5'h00 : ov_r + 5'h01;
            unique case (st_r)
                UPLC_TX_IDLE:
                begin
                    line_r <= 1'b1;  // see RULE13
                    if (fo_valid && fo_ready)
                    begin
                        sh_r <= fo_data;
                        st_r <= UPLC_TX_START;
                        ov_r <= 5'h00;
                    end
                end
                UPLC_TX_START:
                begin
                    line_r <= 1'b0;
                    if (bit_end)
                    begin
                        st_r  <= UPLC_TX_DATA;
                        bit_r <= 3'h0;
                    end
                end
                UPLC_TX_DATA:
                begin
                    line_r <= sh_r[bit_r];
                    if (bit_end)
                    begin
                        bit_r <= bit_r + 3'h1;
                        if (bit_r == 3'h7)
                            st_r <= UPLC_TX_STOP;
                    end
                end
                UPLC_TX_STOP:
                begin
                    line_r <= 1'b1;
                    if (bit_end)
                        st_r <= UPLC_TX_IDLE;
                end
            endcase
        end
    end
    assign tx = loop ? 1'b1 : line_r;  // see RULE13 RULE14

    // Receiver sees own stream in loopback; remote idles high otherwise
    wire rx_in = loop ? line_r : s_rx;  // see RULE11 RULE12
    logic [7:0] rsh_r;
    logic [3:0] rcnt_r;
    logic [4:0] rov_r;
    logic       rbusy_r;
    wire rhr_rd = rd_pulse && !dlab && hit(s_addr, `UPLC_ADDR_RHR);
    always_ff @(posedge clk or posedge srst)
    begin
        if (srst)
        begin
            rsh_r <= 8'h00;
            rcnt_r <= 4'h0;
            rov_r <= 5'h00;
            rbusy_r <= 1'b0;
            rbr_r <= 8'h00;
            rbr_full_r <= 1'b0;
        end
        else if (soft_clear)
        begin
            rbusy_r <= 1'b0;
            rbr_full_r <= 1'b0;
        end
        else
        begin
            if (rhr_rd)
                rbr_full_r <= 1'b0;
            if (tick_r)
            begin
                if (!rbusy_r)
                begin
                    if (!rx_in)
                    begin
                        rbusy_r <= 1'b1;
                        rov_r <= 5'h00;
                        rcnt_r <= 4'h0;
                    end
                end
                else if (rov_r == 5'(OVS - 1))
                begin
                    rov_r <= 5'h00;
                    rcnt_r <= rcnt_r + 4'h1;
                    if (rcnt_r == 4'h9)
                        rbusy_r <= 1'b0;
                end
                else
                begin
                    rov_r <= rov_r + 5'h01;
                    if (rov_r == 5'(OVS / 2) && rcnt_r >= 4'h1 &&
                        rcnt_r <= 4'h8)
                        rsh_r <= {rx_in, rsh_r[7:1]};
                    if (rov_r == 5'(OVS / 2) && rcnt_r == 4'h9)
                    begin
                        rbr_r <= rsh_r;
                        rbr_full_r <= 1'b1;
                    end
                end
            end
        end
    end

    // Read mux; bus is isolated while low power is requested
    wire [7:0] msr_v = {1'b0, !s_ri_n, 3'b000, teri_r, 2'b00};  // see RULE8
    wire [7:0] lsr_v = {1'b0, st_r == UPLC_TX_IDLE && !fo_valid,
                        fi_ready, 4'h0, rbr_full_r};
    wire [7:0] rd_mux =
        hit(s_addr, `UPLC_ADDR_RHR) ? (dlab ? div_r[7:0] : rbr_r) :
        hit(s_addr, `UPLC_ADDR_IER) ? (dlab ? div_r[15:8] : ier_r) :
        hit(s_addr, `UPLC_ADDR_LCR) ? lcr_r :
        hit(s_addr, `UPLC_ADDR_MCTL) ? modem_control_reg_r :
        hit(s_addr, `UPLC_ADDR_LSR) ? lsr_v :
        hit(s_addr, `UPLC_ADDR_MSR) ? msr_v :  // see RULE8
        hit(s_addr, `UPLC_ADDR_SPR) ? spr_r : 8'h00;
    always_ff @(posedge clk or posedge srst)
    begin
        if (srst)
            data_out <= 8'h00;
        else if (rd_pulse)
            data_out <= rd_mux;
    end
    assign data_oe = rd_lvl;  // see RULE1 RULE4 RULE16

    property p_rts_follows_ctrl;
        @(posedge clk) disable iff (srst)
        wr_pulse && hit(s_addr, `UPLC_ADDR_MCTL) && !soft_clear
            |=> rts_n == !$past(s_din[`UPLC_MCTL_RTS_BIT]);
    endproperty
    a_rts_follows_ctrl: assert property (p_rts_follows_ctrl)  // see RULE9
        else $error("rts_n does not follow control bit 1");

    property p_rts_after_lp;
        @(posedge clk) disable iff (srst)
        soft_clear |=> rts_n;
    endproperty
    a_rts_after_lp: assert property (p_rts_after_lp)  // see RULE10
        else $error("rts_n not high after low-power reset");

    property p_lp_fall_reset;
        @(posedge clk) disable iff (srst)
        $fell(s_lp) |-> ##1 soft_clear ##1
            (modem_control_reg_r == `UPLC_MCTL_RST);
    endproperty
    a_lp_fall_reset: assert property (p_lp_fall_reset)  // see RULE5
        else $error("no automatic reset after low power exit");

    property p_lp_isolates;
        @(posedge clk) disable iff (srst)
        s_lp |-> !data_oe && !osc_out;
    endproperty
    a_lp_isolates: assert property (p_lp_isolates)  // see RULE4
        else $error("bus or oscillator active in low power");

    property p_ri_irq;
        @(posedge clk) disable iff (srst)
        ri_rise && !soft_clear && ier_r[`UPLC_IER_MSI_BIT] |=> msi_irq;
    endproperty
    a_ri_irq: assert property (p_ri_irq)  // see RULE7
        else $error("ring rise did not raise interrupt");

    property p_loop_tx_high;
        @(posedge clk) disable iff (srst)
        loop |-> tx;
    endproperty
    a_loop_tx_high: assert property (p_loop_tx_high)  // see RULE14
        else $error("tx driven during loopback");

    property p_idle_tx_high;
        @(posedge clk) disable iff (srst)
        (st_r == UPLC_TX_IDLE) ##1 (st_r == UPLC_TX_IDLE) |-> tx;
    endproperty
    a_idle_tx_high: assert property (p_idle_tx_high)  // see RULE13
        else $error("tx low while idle");

    property p_cs_gate;
        @(posedge clk) disable iff (srst)
        s_cs_n |-> !rd_pulse && !wr_pulse && !data_oe;
    endproperty
    a_cs_gate: assert property (p_cs_gate)  // see RULE16
        else $error("access taken without chip select");

    c_lp_cycle:  cover property (@(posedge clk) $fell(s_lp));
    c_ri_irq:    cover property (@(posedge clk) $rose(msi_irq));
    c_loop_rx:   cover property (@(posedge clk) loop && $rose(rbr_full_r));
    c_style_wr:  cover property (@(posedge clk) !s_style && wr_pulse);
endmodule // uplc_core

// >>> uplc_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module uplc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             flush,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];

    always_ff @(posedge clk)
    begin
        if (push)
            mem_r[wp_r] <= in_data;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else if (flush)
        begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push)
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            if (pop)
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // uplc_fifo

// >>> uplc_params.svh
// Constants for the UART pin-level control block
`ifndef UPLC_PARAMS_SVH
`define UPLC_PARAMS_SVH
`define UPLC_ADDR_RHR        3'h0
`define UPLC_ADDR_IER        3'h1
`define UPLC_ADDR_LCR        3'h3
`define UPLC_ADDR_MCTL       3'h4
`define UPLC_ADDR_LSR        3'h5
`define UPLC_ADDR_MSR        3'h6
`define UPLC_ADDR_SPR        3'h7
`define UPLC_IER_MSI_BIT     3
`define UPLC_MCTL_RTS_BIT    1
`define UPLC_MCTL_LOOP_BIT   4
`define UPLC_MSR_RI_BIT      6
`define UPLC_MSR_TERI_BIT    2
`define UPLC_LSR_DR_BIT      0
`define UPLC_LSR_THRE_BIT    5
`define UPLC_LSR_TEMT_BIT    6
`define UPLC_IER_RST         8'h00
`define UPLC_MCTL_RST        8'h00
`define UPLC_LCR_RST         8'h00
`define UPLC_DIV_RST         16'h0001
`define UPLC_FIFO_DEPTH      32
`define UPLC_OVS             16
`endif

// >>> uplc_pkg.sv
// Types for the UART pin-level control block
package uplc_pkg;
    typedef enum logic [3:0]
    {
        UPLC_TX_IDLE  = 4'b0001,
        UPLC_TX_START = 4'b0010,
        UPLC_TX_DATA  = 4'b0100,
        UPLC_TX_STOP  = 4'b1000
    } uplc_tx_state_t;
endpackage

// >>> uplc_serial_peer.sv
// Remote serial device model: 8N1 sender and receiver
`timescale 1ns/10ps
module uplc_serial_peer #(
    parameter int BIT_NS = 256
) (
    input  wire logic tx,
    output logic      rx
);
    logic [7:0] got_byte;
    int         got_count;
    logic [7:0] sh;

    initial
    begin
        rx = 1'b1; // Idle high from time zero
        got_byte = 8'h00;
        got_count = 0;
    end

    task automatic send(input logic [7:0] b);
        rx = 1'b0;
        #(BIT_NS);
        for (int i = 0; i < 8; i++)
        begin
            rx = b[i];
            #(BIT_NS);
        end
        rx = 1'b1; // Stop bit, then line stays high
        #(BIT_NS);
    endtask

    // Mid-bit sampling, LSB first; a bad stop bit drops the byte
    always @(negedge tx)
    begin
        #(BIT_NS / 2);
        if (tx === 1'b0)
        begin
            for (int i = 0; i < 8; i++)
            begin
                #(BIT_NS);
                sh[i] = tx;
            end
            #(BIT_NS);
            if (tx === 1'b1)
            begin
                got_byte = sh;
                got_count = got_count + 1;
            end
        end
    end
endmodule // uplc_serial_peer
